// ---- ifd_pkg.sv ----
// Shared constants for the instruction format decoder.
package ifd_pkg;

  // ****************************************
  // Instruction formats
  // ****************************************
  typedef enum logic [2:0] {
    FMT_ONE_BYTE,
    FMT_SHORT_REL,
    FMT_IMM8,
    FMT_ADDR8,
    FMT_ABS16,
    FMT_ADDR_IMM,
    FMT_ADDR_ADDR
  } ifd_format_e;

  localparam int unsigned FORMAT_COUNT = 7;

  // ****************************************
  // Opcodes with special decode
  // ****************************************
  localparam logic [7:0] OP_SUPERVISORY_CALL = 8'h00;
  localparam logic [7:0] OP_NO_OPERATION = 8'h40;
  localparam logic [7:0] OP_HALT = 8'h30;
  localparam logic [7:0] OP_PUSH_A = 8'h08;
  localparam logic [7:0] OP_PUSH_X = 8'h10;
  localparam logic [7:0] OP_LONG_JUMP = 8'h7D;
  localparam logic [7:0] OP_LONG_CALL = 8'h7C;
  localparam logic [7:0] OP_MOVE_MEM_MEM = 8'h5F;
  localparam logic [7:0] OP_AND_FLAGS = 8'h70;
  localparam logic [7:0] OP_OR_FLAGS = 8'h71;
  localparam logic [7:0] OP_XOR_FLAGS = 8'h72;
  localparam logic [7:0] OP_MVI_LOAD = 8'h3E;
  localparam logic [7:0] OP_MVI_STORE = 8'h3F;
  localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'hFF;

  // ****************************************
  // Processor flag register
  // ****************************************
  localparam logic [7:0] FLAGS_ADDR = 8'hF7;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_WMASK = 8'hD7;
  localparam int unsigned FLAG_PAGE_HI = 7;
  localparam int unsigned FLAG_PAGE_LO = 6;
  localparam int unsigned FLAG_BANK = 4;
  localparam int unsigned FLAG_CARRY = 2;
  localparam int unsigned FLAG_ZERO = 1;
  localparam int unsigned FLAG_IRQ_EN = 0;

  // ****************************************
  // Avalon register map, word byte addresses
  // ****************************************
  localparam logic [9:0] REG_FLAGS = 10'h3DC;
  localparam logic [9:0] REG_CONTROL = 10'h000;
  localparam logic [9:0] REG_PC = 10'h004;
  localparam logic [9:0] REG_STATUS = 10'h008;
  localparam logic [9:0] REG_OPERANDS = 10'h00C;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_IRQ_TAKE = 1;

  // ****************************************
  // Paging and bus constants
  // ****************************************
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned PAGE_BITS = 7;
  localparam logic [31:0] BUS_ERR_WORD = 32'hDEAD_BEEF;

endpackage

// ---- ifd_length_decode.sv ----
// Opcode to format and length lookup for the instruction decoder.
module ifd_length_decode (
  // Opcode in
  input wire logic [7:0] opcode,
  // Format and byte count out
  output ifd_pkg::ifd_format_e format,
  output logic [1:0] length
);

  // One-byte opcodes are the accumulator, index and stack forms; the rest
  // follow the row and column shape of the opcode map.
  always_comb begin
    format = ifd_pkg::FMT_ADDR8;
    if (opcode[7:4] >= 4'h8) begin
      format = ifd_pkg::FMT_SHORT_REL;
    end else if (opcode == ifd_pkg::OP_LONG_JUMP || opcode == ifd_pkg::OP_LONG_CALL) begin
      format = ifd_pkg::FMT_ABS16;
    end else if (opcode == ifd_pkg::OP_MOVE_MEM_MEM) begin
      format = ifd_pkg::FMT_ADDR_ADDR;
    end else if (opcode == ifd_pkg::OP_SUPERVISORY_CALL || opcode == ifd_pkg::OP_NO_OPERATION ||
                 opcode == ifd_pkg::OP_HALT || opcode == ifd_pkg::OP_PUSH_A ||
                 opcode == ifd_pkg::OP_PUSH_X || opcode[7:4] == 4'h6 && opcode[1:0] != 2'b10 ||
                 opcode[7:3] == 5'b0111_1 || opcode == 8'h4B || opcode == 8'h4E ||
                 opcode == 8'h73 || opcode == 8'h74 || opcode == 8'h75 || opcode == 8'h7E ||
                 opcode == 8'h7F || opcode == 8'h18 || opcode == 8'h20 || opcode == 8'h28) begin
      format = ifd_pkg::FMT_ONE_BYTE;
    end else if (opcode[2:0] == 3'h1 || opcode[7:4] == 4'h7 && opcode[3:0] <= 4'h2) begin
      format = ifd_pkg::FMT_IMM8;
    end else if (opcode[2:0] == 3'h6 || opcode[2:0] == 3'h7) begin
      format = ifd_pkg::FMT_ADDR_IMM;
    end
  end

  always_comb begin
    case (format)
      ifd_pkg::FMT_ONE_BYTE: length = 2'd1;
      ifd_pkg::FMT_ABS16, ifd_pkg::FMT_ADDR_IMM, ifd_pkg::FMT_ADDR_ADDR: length = 2'd3;
      default: length = 2'd2;
    endcase
  end

endmodule

// ---- ifd_format_decoder.sv ----
// Instruction fetch, format decode and processor flag register.
//
// Our own choice: the Avalon-MM register port.

module ifd_format_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Program fetch bus
  output logic [15:0] fetchAddr,
  output logic fetchRead,
  input wire logic [7:0] fetchData,
  // Core datapath side
  input wire logic aluFlagValid,
  input wire logic aluCarry,
  input wire logic aluZero,
  input wire logic irqRequest,
  output logic instrValid,
  output logic [7:0] instrOpcode,
  output logic [15:0] instrOperand,
  output logic [2:0] instrFormat,
  output logic [1:0] instrLength,
  output logic [11:0] shortOffset,
  output logic [15:0] branchTarget,
  output logic ramWrite,
  output logic stackIncrement,
  output logic regWrite,
  output logic [8:0] regAddr,
  output logic superCall,
  output logic irqTaken,
  output logic [1:0] page_addressing_select,
  output logic register_bank_select,
  output logic global_irq_enable,
  output logic [7:0] processor_flags
);

  // ****************************************
  // Fetch sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_OPERAND,
    ST_PAGE_PENALTY,
    ST_ISSUE,
    ST_IRQ_PUSH
  } ifd_state_e;

  ifd_state_e state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] start_q, start_d;
  logic [7:0] opcode_q, opcode_d;
  logic [15:0] operand_q, operand_d;
  logic [1:0] count_q, count_d;
  logic [7:0] flags_q, flags_d;
  logic run_q, run_d;
  logic irqSync1_q, irqSync2_q;
  logic irqPending_q, irqPending_d;
  logic [7:0] issueFlags_q, issueFlags_d;
  ifd_pkg::ifd_format_e decFormat;
  logic [1:0] decLength;
  logic [15:0] lastAddr;
  logic crossPage;
  logic [15:0] target_q, target_d;
  logic ack_q, ack_d;
  logic busWriteFlags, busWriteCtrl, busWritePc, busRead;
  logic [7:0] flagsBus;

  ifd_length_decode u_len (
    .opcode(state_q == ST_OPCODE ? fetchData : opcode_q),
    .format(decFormat),
    .length(decLength)
  );

  assign fetchAddr = pc_q;
  assign fetchRead = state_q == ST_OPCODE || state_q == ST_OPERAND;

  assign lastAddr = start_q + 16'(decLength) - 16'd1;
  assign crossPage = start_q[15:ifd_pkg::PAGE_BITS] != lastAddr[15:ifd_pkg::PAGE_BITS];

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    start_d = start_q;
    opcode_d = opcode_q;
    operand_d = operand_q;
    count_d = count_q;
    target_d = target_q;
    irqPending_d = irqPending_q;
    case (state_q)
      ST_IDLE: begin
        if (run_q) begin
          state_d = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        opcode_d = fetchData;
        start_d = pc_q;
        pc_d = pc_q + 16'd1;
        operand_d = 16'h0000;
        count_d = decLength - 2'd1;
        target_d = pc_q + 16'd1;
        state_d = decLength == 2'd1 ? (crossPage ? ST_PAGE_PENALTY : ST_ISSUE) : ST_OPERAND;
      end
      ST_OPERAND: begin
        operand_d = {operand_q[7:0], fetchData};
        pc_d = pc_q + 16'd1;
        count_d = count_q - 2'd1;
        if (count_q == 2'd1) begin
          state_d = crossPage ? ST_PAGE_PENALTY : ST_ISSUE;
          if (decFormat == ifd_pkg::FMT_SHORT_REL) begin
            target_d = start_q + {{4{opcode_q[3]}}, opcode_q[3:0], fetchData};
          end else if (decFormat == ifd_pkg::FMT_ABS16) begin
            target_d = operand_d;
          end else begin
            target_d = pc_q + 16'd1;
          end
        end
      end
      ST_PAGE_PENALTY: state_d = ST_ISSUE;
      ST_ISSUE: begin
        // The target is settled while the last byte comes in, so it can stand at issue.
        pc_d = target_q;
        irqPending_d = flags_q[ifd_pkg::FLAG_IRQ_EN] && irqSync2_q;
        state_d = irqPending_d ? ST_IRQ_PUSH : (run_q ? ST_OPCODE : ST_IDLE);
      end
      ST_IRQ_PUSH: begin
        irqPending_d = 1'b0;
        state_d = run_q ? ST_OPCODE : ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    // A program counter write is honoured only once run is off. Software must let
    // the sequencer drain to idle first, or the instruction in flight is cut.
    if (busWritePc && !run_q) begin
      pc_d = avsWritedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      pc_q <= 16'h0000;
      start_q <= 16'h0000;
      opcode_q <= 8'h00;
      operand_q <= 16'h0000;
      count_q <= 2'd0;
      target_q <= 16'h0000;
      irqPending_q <= 1'b0;
      irqSync1_q <= 1'b0;
      irqSync2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      start_q <= start_d;
      opcode_q <= opcode_d;
      operand_q <= operand_d;
      count_q <= count_d;
      target_q <= target_d;
      irqPending_q <= irqPending_d;
      irqSync1_q <= irqRequest;
      irqSync2_q <= irqSync1_q;
    end
  end

  // ****************************************
  // Issue outputs
  // ****************************************
  logic isIssue;
  assign isIssue = state_q == ST_ISSUE;
  assign instrValid = isIssue;
  assign instrOpcode = opcode_q;
  assign instrOperand = operand_q;
  assign instrFormat = 3'(decFormat);
  assign instrLength = decLength;
  assign shortOffset = {opcode_q[3:0], operand_q[7:0]};
  assign branchTarget = target_q;
  assign superCall = isIssue && opcode_q == ifd_pkg::OP_SUPERVISORY_CALL;
  assign ramWrite = isIssue && (opcode_q == ifd_pkg::OP_PUSH_A || opcode_q == ifd_pkg::OP_PUSH_X) ||
                    state_q == ST_IRQ_PUSH;
  assign stackIncrement = ramWrite;
  // bank bit is ninth address bit
  assign regWrite = isIssue && opcode_q == ifd_pkg::OP_HALT;
  assign regAddr = regWrite ? {1'b0, ifd_pkg::SYSTEM_CONTROL_ADDR} :
                   {flags_q[ifd_pkg::FLAG_BANK], operand_q[15:8]};
  assign irqTaken = state_q == ST_IRQ_PUSH;
  // no-op and call raise nothing else
  // other one-byte effects belong to the datapath via instrOpcode
  // operand bytes as fetched, in order

  // ****************************************
  // Processor flag register
  // ****************************************
  // Writes land only at the edge where waitrequest is low, never at the first one.
  always_comb begin
    busWriteFlags = 1'b0;
    busWriteCtrl = 1'b0;
    busWritePc = 1'b0;
    if (avsWrite && ack_q && avsByteenable[0]) begin
      case (avsAddress)
        ifd_pkg::REG_FLAGS: busWriteFlags = 1'b1;
        ifd_pkg::REG_CONTROL: busWriteCtrl = 1'b1;
        ifd_pkg::REG_PC: busWritePc = 1'b1;
        default: busWriteFlags = 1'b0;
      endcase
    end
  end
  assign busRead = avsRead;
  assign flagsBus = avsWritedata[7:0] & ifd_pkg::FLAGS_WMASK;

  always_comb begin
    flags_d = flags_q;
    issueFlags_d = issueFlags_q;
    if (aluFlagValid) begin
      flags_d[ifd_pkg::FLAG_CARRY] = aluCarry;
      flags_d[ifd_pkg::FLAG_ZERO] = aluZero;
    end
    if (isIssue) begin
      case (opcode_q)
        ifd_pkg::OP_AND_FLAGS: flags_d = flags_q & operand_q[7:0] & ifd_pkg::FLAGS_WMASK;
        ifd_pkg::OP_OR_FLAGS: flags_d = (flags_q | operand_q[7:0]) & ifd_pkg::FLAGS_WMASK;
        ifd_pkg::OP_XOR_FLAGS: flags_d = (flags_q ^ operand_q[7:0]) & ifd_pkg::FLAGS_WMASK;
        default: flags_d = flags_d;
      endcase
      issueFlags_d = flags_q;
    end
    // supervisory ROM runs in page 0
    if (superCall) begin
      flags_d[ifd_pkg::FLAG_PAGE_HI] = 1'b0;
      flags_d[ifd_pkg::FLAG_PAGE_LO] = 1'b0;
    end
    if (busWriteFlags) begin
      flags_d = flagsBus;
    end
    if (state_q == ST_IRQ_PUSH) begin
      flags_d[ifd_pkg::FLAG_IRQ_EN] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= ifd_pkg::FLAGS_RESET;
      issueFlags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
      issueFlags_q <= issueFlags_d;
    end
  end

  // page mode bits drive the paging logic
  assign page_addressing_select = flags_q[ifd_pkg::FLAG_PAGE_HI:ifd_pkg::FLAG_PAGE_LO];
  assign register_bank_select = flags_q[ifd_pkg::FLAG_BANK];
  assign global_irq_enable = flags_q[ifd_pkg::FLAG_IRQ_EN];
  assign processor_flags = flags_q;

  // ****************************************
  // Avalon slave
  // ****************************************
  logic [31:0] rdata_q, rdata_d;

  // One wait cycle per access keeps read data registered.
  assign avsWaitrequest = (avsRead || avsWrite) && !ack_q;
  assign avsReaddata = rdata_q;

  always_comb begin
    run_d = run_q;
    ack_d = (avsRead || avsWrite) && !ack_q;
    rdata_d = rdata_q;
    if (busWriteCtrl) begin
      run_d = avsWritedata[ifd_pkg::CTRL_RUN];
    end
    if (busRead && !ack_q) begin
      case (avsAddress)
        ifd_pkg::REG_FLAGS: rdata_d = {24'h0000_00, flags_q};
        ifd_pkg::REG_CONTROL: rdata_d = {31'h0000_0000, run_q};
        ifd_pkg::REG_PC: rdata_d = {16'h0000, pc_q};
        ifd_pkg::REG_STATUS: rdata_d = {16'h0000, issueFlags_q, 5'h00, 3'(state_q)};
        ifd_pkg::REG_OPERANDS: rdata_d = {8'h00, opcode_q, operand_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      run_q <= run_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule

// ---- ifd_prog_mem.sv ----
// Combinational program memory model on the decoder's fetch bus.
module ifd_prog_mem (
  // Fetch bus
  input wire logic [15:0] fetchAddr,
  input wire logic fetchRead,
  output logic [7:0] fetchData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] lastByte = 8'h00;
  // Unused places hold the one-byte no-op, so stray fetches stay harmless.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ifd_pkg::OP_NO_OPERATION;
    end
  end
  // Released bus shows the inverse of the last byte so stale data cannot pass.
  // own fetch bus
  always @* begin
    if (fetchRead) begin
      lastByte = mem[fetchAddr[7:0]];
    end
    fetchData = fetchRead ? mem[fetchAddr[7:0]] : ~lastByte;
  end
endmodule

// ---- ifd_chk.sv ----
// Port-level assertions for the instruction format decoder.
module ifd_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus handshake
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  // Issue
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic [15:0] instrOperand,
  input wire logic [2:0] instrFormat,
  input wire logic [1:0] instrLength,
  input wire logic [15:0] branchTarget,
  // Side effects
  input wire logic ramWrite,
  input wire logic stackIncrement,
  input wire logic regWrite,
  input wire logic [8:0] regAddr,
  input wire logic superCall,
  input wire logic irqTaken,
  // Flags
  input wire logic [1:0] page_addressing_select,
  input wire logic register_bank_select,
  input wire logic global_irq_enable,
  input wire logic [7:0] processor_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    $rose(avsRead || avsWrite);
  endsequence
  sequence s_answer;
    avsWaitrequest ##1 !avsWaitrequest;
  endsequence
  property p_bus_answer;
    s_req |-> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not in second cycle");
  property p_reset;
    $rose(nrst) |-> processor_flags == ifd_pkg::FLAGS_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("flag reset value wrong");
  property p_page;
    page_addressing_select == processor_flags[7:6];
  endproperty
  a_page: assert property (p_page)
    else $error("page select not flag bits 7:6");
  property p_bank;
    register_bank_select == processor_flags[4] && processor_flags[5] == 1'b0 && processor_flags[3] == 1'b0;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select or reserved flag bits wrong");
  property p_irq_en;
    global_irq_enable == processor_flags[0] and (irqTaken |-> global_irq_enable ##1 !global_irq_enable);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt enable misbehaves");
  property p_nop;
    instrValid && (instrOpcode == ifd_pkg::OP_NO_OPERATION || instrOpcode == ifd_pkg::OP_SUPERVISORY_CALL)
      |-> !ramWrite && !regWrite && !stackIncrement;
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op or call wrote state");
  property p_super;
    superCall |-> instrValid && instrOpcode == ifd_pkg::OP_SUPERVISORY_CALL;
  endproperty
  a_super: assert property (p_super)
    else $error("supervisory call pulse stray");
  property p_push;
    instrValid && (instrOpcode == ifd_pkg::OP_PUSH_A || instrOpcode == ifd_pkg::OP_PUSH_X) |-> ramWrite && stackIncrement;
  endproperty
  a_push: assert property (p_push)
    else $error("push without ram write");
  property p_halt;
    regWrite |-> instrValid && instrOpcode == ifd_pkg::OP_HALT && regAddr == 9'h0FF;
  endproperty
  a_halt: assert property (p_halt)
    else $error("register write not halt at FFh");
  property p_long;
    instrValid && (instrOpcode == ifd_pkg::OP_LONG_JUMP || instrOpcode == ifd_pkg::OP_LONG_CALL)
      |-> instrLength == 2'd3 && instrFormat == ifd_pkg::FMT_ABS16 && branchTarget == instrOperand;
  endproperty
  a_long: assert property (p_long)
    else $error("long branch decode wrong");
  property p_move;
    instrValid && instrOpcode == ifd_pkg::OP_MOVE_MEM_MEM |-> instrFormat == ifd_pkg::FMT_ADDR_ADDR && instrLength == 2'd3;
  endproperty
  a_move: assert property (p_move)
    else $error("memory move decode wrong");
  property p_one;
    instrValid && instrFormat == ifd_pkg::FMT_ONE_BYTE |-> instrLength == 2'd1;
  endproperty
  a_one: assert property (p_one)
    else $error("one-byte length wrong");
endmodule
bind ifd_format_decoder ifd_chk i_chk (.clk(clk), .nrst(nrst), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWaitrequest(avsWaitrequest), .instrValid(instrValid), .instrOpcode(instrOpcode), .instrOperand(instrOperand),
  .instrFormat(instrFormat), .instrLength(instrLength), .branchTarget(branchTarget), .ramWrite(ramWrite),
  .stackIncrement(stackIncrement), .regWrite(regWrite), .regAddr(regAddr), .superCall(superCall),
  .irqTaken(irqTaken), .page_addressing_select(page_addressing_select),
  .register_bank_select(register_bank_select), .global_irq_enable(global_irq_enable),
  .processor_flags(processor_flags));

// ---- testbench.sv ----
// Self-checking bench for the instruction format decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = '0;
  logic [3:0] avsByteenable = '0;
  logic aluFlagValid = 1'b0;
  logic aluCarry = 1'b0;
  logic aluZero = 1'b0;
  logic irqRequest = 1'b0;
  logic [31:0] avsReaddata, rd;
  logic avsWaitrequest, fetchRead, instrValid, ramWrite, stackIncrement, regWrite, superCall, irqTaken;
  logic register_bank_select, global_irq_enable;
  logic [15:0] fetchAddr, instrOperand, branchTarget;
  logic [7:0] fetchData, instrOpcode, processor_flags;
  logic [2:0] instrFormat;
  logic [1:0] instrLength, page_addressing_select;
  logic [11:0] shortOffset;
  logic [8:0] regAddr;
  logic [31:0] seen [$];
  logic [7:0] prog [23] = '{8'h40, 8'h08, 8'h30, 8'h7D, 8'h00, 8'h10, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40,
    8'h40, 8'h40, 8'h40, 8'h40, 8'h5F, 8'h07, 8'h05, 8'h72, 8'h01, 8'h80, 8'h00};
  logic [31:0] expIssue [7];
  int nIrq = 0;
  logic [27:0] shortSeen = '0;
  int n_mismatch = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  ifd_format_decoder i_dut (.clk(clk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .fetchAddr(fetchAddr), .fetchRead(fetchRead), .fetchData(fetchData),
    .aluFlagValid(aluFlagValid), .aluCarry(aluCarry), .aluZero(aluZero), .irqRequest(irqRequest),
    .instrValid(instrValid), .instrOpcode(instrOpcode), .instrOperand(instrOperand), .instrFormat(instrFormat),
    .instrLength(instrLength), .shortOffset(shortOffset), .branchTarget(branchTarget), .ramWrite(ramWrite),
    .stackIncrement(stackIncrement), .regWrite(regWrite), .regAddr(regAddr), .superCall(superCall),
    .irqTaken(irqTaken), .page_addressing_select(page_addressing_select),
    .register_bank_select(register_bank_select), .global_irq_enable(global_irq_enable),
    .processor_flags(processor_flags));
  ifd_prog_mem i_mem (.fetchAddr(fetchAddr), .fetchRead(fetchRead), .fetchData(fetchData));
  // ****************************************
  // Monitor and tasks
  // ****************************************
  // Sampling on the falling edge keeps the monitor clear of the flops' own updates.
  always @(negedge clk) begin
    if (instrValid === 1'b1) begin
      seen.push_back({instrOpcode, instrOperand, instrFormat, instrLength, ramWrite, regWrite, superCall});
      if (instrOpcode == 8'h80) begin
        shortSeen = {shortOffset, branchTarget};
      end
    end
    if (irqTaken === 1'b1) begin
      nIrq++;
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [9:0] a, logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= 4'h1;
    avsWrite <= wr;
    avsRead <= !wr;
    // The request stands until the rising edge at which waitrequest is seen low.
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rec(logic [7:0] op, logic [15:0] od, logic [2:0] f, logic [1:0] n, logic [2:0] fx);
    return {op, od, f, n, fx};
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    expIssue = '{rec(8'h40, 0, ifd_pkg::FMT_ONE_BYTE, 1, 0), rec(8'h08, 0, ifd_pkg::FMT_ONE_BYTE, 1, 3'b100),
      rec(8'h30, 0, ifd_pkg::FMT_ONE_BYTE, 1, 3'b010), rec(8'h7D, 16'h0010, ifd_pkg::FMT_ABS16, 3, 0),
      rec(8'h5F, 16'h0705, ifd_pkg::FMT_ADDR_ADDR, 3, 0), rec(8'h72, 16'h0001, ifd_pkg::FMT_IMM8, 2, 0),
      rec(8'h80, 16'h0000, ifd_pkg::FMT_SHORT_REL, 2, 0)};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(0, ifd_pkg::REG_FLAGS, 0);
    check("flags after reset", 32'h0000_0002, rd);
    bus(0, 10'h100, 0);
    check("unmapped read", 32'h0000_0000, rd);
    for (int i = 0; i < 23; i++) begin
      i_mem.mem[i] = prog[i];
    end
    i_mem.mem[8'h30] = ifd_pkg::OP_SUPERVISORY_CALL;
    bus(1, ifd_pkg::REG_PC, 0);
    bus(1, ifd_pkg::REG_CONTROL, 1);
    while (seen.size() < 7) @(posedge clk);
    // One-byte records carry no operand, so their operand field is masked off.
    for (int i = 0; i < 7; i++) begin
      check("issue", expIssue[i], seen[i] & (i < 3 ? 32'hFF00_00FF : 32'hFFFF_FFFF));
    end
    check("short target", 32'h0000_0015, {4'h0, shortSeen});
    bus(0, ifd_pkg::REG_FLAGS, 0);
    check("flags after xor", 32'h0000_0003, rd);
    bus(1, ifd_pkg::REG_FLAGS, 32'h0000_00D6);
    bus(0, ifd_pkg::REG_FLAGS, 0);
    check("flags written", 32'h0000_00D6, rd);
    check("bank and page", 32'h7, {register_bank_select, page_addressing_select});
    bus(1, ifd_pkg::REG_FLAGS, 0);
    @(posedge clk);
    aluFlagValid <= 1'b1;
    aluCarry <= 1'b1;
    @(posedge clk);
    aluFlagValid <= 1'b0;
    aluCarry <= 1'b0;
    bus(0, ifd_pkg::REG_FLAGS, 0);
    check("alu flags", 32'h0000_0004, rd);
    irqRequest <= 1'b1;
    repeat (40) @(posedge clk);
    check("irq ignored", 0, nIrq);
    bus(1, ifd_pkg::REG_FLAGS, 1);
    for (int i = 0; i < 100 && nIrq == 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("irq taken", 1, nIrq);
    check("irq enable", 0, global_irq_enable);
    bus(1, ifd_pkg::REG_CONTROL, 0);
    bus(1, ifd_pkg::REG_PC, 32'h0000_0030);
    seen.delete();
    bus(1, ifd_pkg::REG_CONTROL, 1);
    while (seen.size() < 1) @(posedge clk);
    check("supervisory call", rec(8'h00, 0, ifd_pkg::FMT_ONE_BYTE, 1, 3'b001), seen[0] & 32'hFF00_00FF);
    tally_and_finish();
  end
endmodule
